// *** hw/rtca_alarm_regs.sv ***
// rtca_alarm_regs: alarm configuration, alarm window and bcd time value registers
//
// Behaviour
// R1 - setting arm enables alarm; cleared after event with count zero and no chime
// R2 - with chime set, repeat count wraps from zero to all ones on event
// R3 - with chime clear, repeat count stays at zero once there
// R4 - four-bit interval code selects half second up to yearly alarm period
// R5 - yearly alarm on february 29 fires only when that date occurs
// R6 - software never writes reserved interval codes 101x or 11xx
// R7 - window pointer selects min/sec, weekday/hour, month/day pair; 11 unimplemented
// R8 - access to upper byte of alarm window decrements pointer, stopping at 00
// R9 - repeat count tells how many further alarms follow the current one
// R10 - repeat count decrements by one on every alarm event while it is nonzero
// R11 - year holds two bcd digits in low byte; upper byte reads zero
// R12 - year writes accepted only while time write unlock is set
// R13 - month tens at bit 12, ones at 11-8; month byte read-only
// R14 - day tens at bits 5-4, ones at 3-0; bits 7-6, 15-13 zero
// R15 - weekday digit in bits 10-8; other upper bits read zero
// R16 - hour tens at bits 5-4, ones at 3-0; bits 7-6 read zero
// R17 - weekday/hour and month/day writes accepted only while unlock is set
// R18 - minutes tens at bits 14-12, ones at 11-8; bit 15 zero
// R19 - seconds tens at bits 6-4, ones at 3-0; bit 7 zero
// R20 - alarm month/day uses same layout with month byte writable
// R21 - unlock set permits time value writes; clear blocks them
// R22 - any read of alarm window also decrements the pointer
// R23 - interval code decides which alarm digits must equal the time
// R24 - every alarm event raises the interrupt output
// R25 - alarm configuration resets to zero on power-on reset
module rtca_alarm_regs (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write address and data
  input  wire logic [rtca_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                awprot,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  // axi4-lite write response
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // axi4-lite read
  input  wire logic [rtca_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                arprot,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // half-second timebase from the time counter (same clock)
  input  wire logic                      half_sec_tick,
  input  wire logic                      second_half,
  // alarm outputs
  output logic                           alarm_event,
  output logic                           alarm_pulse
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  rtca_pkg::rtca_alarm_cfg_t cfg;
  logic [15:0]               year_value;
  logic [15:0]               month_day_value;
  logic [15:0]               weekday_hour_value;
  logic [15:0]               minute_second_value;
  logic [15:0]               alarm_min_sec;
  logic [15:0]               alarm_wday_hour;
  logic [15:0]               alarm_month_day_value;
  logic                      time_write_unlock;
  logic                      aw_hold;
  logic                      w_hold;
  logic [rtca_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0]               wr_data;
  logic [3:0]                wr_strb;
  logic                      do_write;
  logic                      rd_fire;
  logic                      wr_cfg;
  logic                      win_dec;
  logic                      hit;
  logic                      fire;
  logic [31:0]               next_rdata;
  logic [1:0]                next_rresp;
  logic [1:0]                next_bresp;

  // merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  // ----------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------
  // address and data are taken in either order and held until both arrive
  assign awready  = !aw_hold && !bvalid;
  assign wready   = !w_hold && !bvalid;
  assign do_write = aw_hold && w_hold && !bvalid;

  // capture write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      aw_hold <= 1'b1;
      wr_addr <= awaddr;
    end else if (do_write) begin
      aw_hold <= 1'b0;
    end
  end

  // capture write data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold  <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wvalid && wready) begin
      w_hold  <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (do_write) begin
      w_hold <= 1'b0;
    end
  end

  // response decode; unmapped offsets answer slverr
  always_comb begin
    case (wr_addr)
      rtca_pkg::OFF_ALARM_CFG, rtca_pkg::OFF_ALARM_WIN, rtca_pkg::OFF_YEAR,
      rtca_pkg::OFF_MONTH_DAY, rtca_pkg::OFF_WDAY_HOUR, rtca_pkg::OFF_MIN_SEC,
      rtca_pkg::OFF_TIME_CTRL: next_bresp = rtca_pkg::RESP_OKAY;
      default:                 next_bresp = rtca_pkg::RESP_SLVERR;
    endcase
  end

  // write response held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= rtca_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= next_bresp;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------
  assign arready = !rvalid;
  assign rd_fire = arvalid && arready;

  // read mux; the alarm window shows the pair the pointer selects
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = rtca_pkg::RESP_OKAY;
    case (araddr)
      rtca_pkg::OFF_ALARM_CFG: next_rdata[15:0] = cfg;
      rtca_pkg::OFF_ALARM_WIN: begin
        case (cfg.window_ptr)  // see R7
          rtca_pkg::PTR_MIN_SEC:   next_rdata[15:0] = alarm_min_sec;
          rtca_pkg::PTR_WDAY_HOUR: next_rdata[15:0] = alarm_wday_hour;
          rtca_pkg::PTR_MONTH_DAY: next_rdata[15:0] = alarm_month_day_value;
          default:                 next_rdata[15:0] = 16'h0000;
        endcase
      end
      rtca_pkg::OFF_YEAR:      next_rdata[15:0] = year_value;  // see R11
      rtca_pkg::OFF_MONTH_DAY: next_rdata[15:0] = month_day_value;
      rtca_pkg::OFF_WDAY_HOUR: next_rdata[15:0] = weekday_hour_value;
      rtca_pkg::OFF_MIN_SEC:   next_rdata[15:0] = minute_second_value;
      rtca_pkg::OFF_TIME_CTRL: next_rdata[rtca_pkg::UNLOCK_BIT] = time_write_unlock;
      default:                 next_rresp = rtca_pkg::RESP_SLVERR;
    endcase
  end

  // read data registered, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= rtca_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // alarm configuration
  // ----------------------------------------------------------------------
  assign wr_cfg  = do_write && (wr_addr == rtca_pkg::OFF_ALARM_CFG);
  // the core cannot tell byte reads from word reads, so any read counts
  assign win_dec = (rd_fire && (araddr == rtca_pkg::OFF_ALARM_WIN))  // see R22
                || (do_write && (wr_addr == rtca_pkg::OFF_ALARM_WIN) && wr_strb[1]);  // see R8

  // a software write wins over the same-cycle event and pointer step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= rtca_pkg::ALARM_CFG_RESET;  // see R25
    end else begin
      if (fire) begin
        if (cfg.repeat_count != rtca_pkg::REPEAT_LAST) begin
          cfg.repeat_count <= cfg.repeat_count - 8'h01;  // see R10 see R9
        end else if (cfg.chime) begin
          cfg.repeat_count <= rtca_pkg::REPEAT_WRAP;  // see R2
        end else begin
          cfg.arm <= 1'b0;  // see R1 see R3
        end
      end
      if (win_dec && (cfg.window_ptr != rtca_pkg::PTR_MIN_SEC)) begin
        cfg.window_ptr <= cfg.window_ptr - 2'h1;  // see R8
      end
      if (wr_cfg) begin
        cfg <= merge16(cfg, wr_data, wr_strb);  // see R1
      end
    end
  end

  // ----------------------------------------------------------------------
  // alarm value registers behind the window
  // ----------------------------------------------------------------------
  // pointer 11 is unimplemented: writes there land nowhere
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_min_sec         <= rtca_pkg::VALUE_RESET;
      alarm_wday_hour       <= rtca_pkg::VALUE_RESET;
      alarm_month_day_value <= rtca_pkg::VALUE_RESET;
    end else if (do_write && (wr_addr == rtca_pkg::OFF_ALARM_WIN)) begin
      case (cfg.window_ptr)  // see R7
        rtca_pkg::PTR_MIN_SEC:
          alarm_min_sec <= merge16(alarm_min_sec, wr_data, wr_strb)
                           & rtca_pkg::MIN_SEC_MASK;
        rtca_pkg::PTR_WDAY_HOUR:
          alarm_wday_hour <= merge16(alarm_wday_hour, wr_data, wr_strb)
                             & rtca_pkg::WDAY_HOUR_MASK;
        rtca_pkg::PTR_MONTH_DAY:  // see R20
          alarm_month_day_value <= merge16(alarm_month_day_value, wr_data, wr_strb)
                                   & rtca_pkg::MONTH_DAY_MASK;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // time value registers, guarded by the write unlock
  // ----------------------------------------------------------------------
  // unlock control: keep it clear otherwise to stop stray time writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_write_unlock <= 1'b0;
    end else if (do_write && (wr_addr == rtca_pkg::OFF_TIME_CTRL) && wr_strb[0]) begin
      time_write_unlock <= wr_data[rtca_pkg::UNLOCK_BIT];
    end
  end

  // masks keep unimplemented bits at zero so they read back as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      year_value          <= rtca_pkg::VALUE_RESET;
      month_day_value     <= rtca_pkg::VALUE_RESET;
      weekday_hour_value  <= rtca_pkg::VALUE_RESET;
      minute_second_value <= rtca_pkg::VALUE_RESET;
    end else if (do_write && time_write_unlock) begin  // see R21 see R12 see R17
      case (wr_addr)
        rtca_pkg::OFF_YEAR:  // see R11
          year_value <= merge16(year_value, wr_data, wr_strb) & rtca_pkg::YEAR_MASK;
        rtca_pkg::OFF_MONTH_DAY:  // month byte read-only, see R13 see R14
          month_day_value <= merge16(month_day_value, wr_data, {wr_strb[3:1] & 3'h0,
                             wr_strb[0]}) & rtca_pkg::MONTH_DAY_MASK;
        rtca_pkg::OFF_WDAY_HOUR:  // see R15 see R16
          weekday_hour_value <= merge16(weekday_hour_value, wr_data, wr_strb)
                                & rtca_pkg::WDAY_HOUR_MASK;
        rtca_pkg::OFF_MIN_SEC:  // see R18 see R19
          minute_second_value <= merge16(minute_second_value, wr_data, wr_strb)
                                 & rtca_pkg::MIN_SEC_MASK;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // alarm match
  // ----------------------------------------------------------------------
  // a whole second begins at the tick that enters the first half
  logic full_sec;
  logic m_sec1;
  logic m_sec;
  logic m_min1;
  logic m_min;
  logic m_hour;
  logic m_wday;
  logic m_day;
  logic m_month;

  assign full_sec = half_sec_tick && !second_half;
  assign m_sec1   = minute_second_value[3:0]   == alarm_min_sec[3:0];
  assign m_sec    = m_sec1 && (minute_second_value[6:4] == alarm_min_sec[6:4]);
  assign m_min1   = m_sec && (minute_second_value[11:8] == alarm_min_sec[11:8]);
  assign m_min    = m_min1 && (minute_second_value[14:12] == alarm_min_sec[14:12]);
  assign m_hour   = m_min && (weekday_hour_value[5:0] == alarm_wday_hour[5:0]);
  assign m_wday   = m_hour && (weekday_hour_value[10:8] == alarm_wday_hour[10:8]);
  assign m_day    = m_hour && (month_day_value[5:0] == alarm_month_day_value[5:0]);
  // feb 29 only matches in a year that has it, so yearly fires every 4th year
  assign m_month  = m_day && (month_day_value[12:8] == alarm_month_day_value[12:8]);

  // interval code picks which digits must agree, see R23
  always_comb begin
    case (cfg.interval_sel)  // see R4
      rtca_pkg::IVL_HALF_SEC: hit = half_sec_tick;
      rtca_pkg::IVL_SECOND:   hit = full_sec;
      rtca_pkg::IVL_TEN_SEC:  hit = full_sec && m_sec1;
      rtca_pkg::IVL_MINUTE:   hit = full_sec && m_sec;
      rtca_pkg::IVL_TEN_MIN:  hit = full_sec && m_min1;
      rtca_pkg::IVL_HOUR:     hit = full_sec && m_min;
      rtca_pkg::IVL_DAY:      hit = full_sec && m_hour;
      rtca_pkg::IVL_WEEK:     hit = full_sec && m_wday;
      rtca_pkg::IVL_MONTH:    hit = full_sec && m_day;
      rtca_pkg::IVL_YEAR:     hit = full_sec && m_month;  // see R5
      default:                hit = 1'b0;  // reserved codes never fire, see R6
    endcase
  end

  assign fire = cfg.arm && hit;

  // event pulse for the interrupt and a toggle at half the alarm rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_event <= 1'b0;
      alarm_pulse <= 1'b0;
    end else begin
      alarm_event <= fire;  // see R24
      if (fire) begin
        alarm_pulse <= !alarm_pulse;
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_last_event;
    fire && (cfg.repeat_count == rtca_pkg::REPEAT_LAST) && !wr_cfg;
  endsequence

  sequence s_write_start;
    aw_hold && w_hold && !bvalid;
  endsequence

  a_arm_self_clear: assert property (s_last_event and !cfg.chime |=> !cfg.arm)  // see R1
    else $error("arm not cleared after last alarm");
  a_repeat_wrap: assert property (s_last_event and cfg.chime  // see R2
    |=> cfg.arm && (cfg.repeat_count == 8'hFF))
    else $error("repeat count did not wrap with chime");
  a_repeat_hold: assert property (!cfg.chime && (cfg.repeat_count == 8'h00) && !wr_cfg  // see R3
    |=> cfg.repeat_count == 8'h00)
    else $error("repeat count left zero without chime");
  a_repeat_dec: assert property (fire && (cfg.repeat_count != 8'h00) && !wr_cfg  // see R10
    |=> cfg.repeat_count == 8'($past(cfg.repeat_count) - 8'h01))
    else $error("repeat count did not step down");
  a_half_sec_fire: assert property (cfg.arm && (cfg.interval_sel == 4'h0)  // see R4
    && half_sec_tick |=> alarm_event)
    else $error("half second alarm missed");
  a_ptr_read_dec: assert property (rd_fire && (araddr == rtca_pkg::OFF_ALARM_WIN)  // see R22
    && (cfg.window_ptr != 2'h0) && !wr_cfg |=> cfg.window_ptr == 2'($past(cfg.window_ptr) - 2'h1))
    else $error("window read did not step pointer");
  a_ptr_floor: assert property ((cfg.window_ptr == 2'h0) && !wr_cfg  // see R8
    |=> cfg.window_ptr == 2'h0)
    else $error("window pointer moved below zero");
  a_year_locked: assert property (do_write && (wr_addr == rtca_pkg::OFF_YEAR)  // see R12
    && !time_write_unlock |=> $stable(year_value))
    else $error("locked year write took effect");
  a_year_upper: assert property (rd_fire && (araddr == rtca_pkg::OFF_YEAR)  // see R11
    |=> rvalid && (rdata[31:8] == 24'h000000))
    else $error("year upper byte not zero");
  a_irq_event: assert property (fire  // see R24
    |=> alarm_event && (alarm_pulse != $past(alarm_pulse)))
    else $error("alarm event not signalled");
  a_write_resp: assert property (s_write_start |=> bvalid ##0 (!awready && !wready))
    else $error("write response missing");

endmodule : rtca_alarm_regs

// *** hw/rtca_pkg.sv ***
// rtca_pkg: register map, field layouts and codes of the rtc alarm and time value registers
package rtca_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses on the axi4-lite bus)
  // ----------------------------------------------------------------------
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  OFF_ALARM_CFG  = 8'h00;
  localparam logic [7:0]  OFF_ALARM_WIN  = 8'h04;
  localparam logic [7:0]  OFF_YEAR       = 8'h08;
  localparam logic [7:0]  OFF_MONTH_DAY  = 8'h0C;
  localparam logic [7:0]  OFF_WDAY_HOUR  = 8'h10;
  localparam logic [7:0]  OFF_MIN_SEC    = 8'h14;
  localparam logic [7:0]  OFF_TIME_CTRL  = 8'h18;

  // ----------------------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------------------
  localparam logic [15:0] ALARM_CFG_RESET = 16'h0000;
  localparam logic [15:0] VALUE_RESET     = 16'h0000;
  localparam logic [7:0]  REPEAT_WRAP     = 8'hFF;
  localparam logic [7:0]  REPEAT_LAST     = 8'h00;
  localparam logic [1:0]  PTR_MIN_SEC     = 2'h0;
  localparam logic [1:0]  PTR_WDAY_HOUR   = 2'h1;
  localparam logic [1:0]  PTR_MONTH_DAY   = 2'h2;
  localparam int          UNLOCK_BIT      = 0;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // implemented bits of each bcd value register; all others read as zero
  localparam logic [15:0] YEAR_MASK       = 16'h00FF;
  localparam logic [15:0] MONTH_DAY_MASK  = 16'h1F3F;
  localparam logic [15:0] WDAY_HOUR_MASK  = 16'h073F;
  localparam logic [15:0] MIN_SEC_MASK    = 16'h7F7F;

  // alarm interval select codes
  localparam logic [3:0]  IVL_HALF_SEC    = 4'h0;
  localparam logic [3:0]  IVL_SECOND      = 4'h1;
  localparam logic [3:0]  IVL_TEN_SEC     = 4'h2;
  localparam logic [3:0]  IVL_MINUTE      = 4'h3;
  localparam logic [3:0]  IVL_TEN_MIN     = 4'h4;
  localparam logic [3:0]  IVL_HOUR        = 4'h5;
  localparam logic [3:0]  IVL_DAY         = 4'h6;
  localparam logic [3:0]  IVL_WEEK        = 4'h7;
  localparam logic [3:0]  IVL_MONTH       = 4'h8;
  localparam logic [3:0]  IVL_YEAR        = 4'h9;

  // alarm configuration register layout, bit 15 down to bit 0
  typedef struct packed {
    logic       arm;
    logic       chime;
    logic [3:0] interval_sel;
    logic [1:0] window_ptr;
    logic [7:0] repeat_count;
  } rtca_alarm_cfg_t;

endpackage : rtca_pkg

// *** test/tb_top.sv ***
// tb_top: self-checking bench for the rtc alarm and time value registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // signals, tables and model state
  // ------------------------------------------------
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, rsp;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, alarm_event, alarm_pulse;
  logic        half_sec_tick = 0, second_half = 0;
  logic        m_hit = 1'b0;
  logic [15:0] m_cfg, nv;
  logic [15:0] v[3];
  int          failures = 0, samples_checked = 0, ev_cnt = 0, m_ev = 0;
  logic [7:0]  offs[4] = '{rtca_pkg::OFF_YEAR, rtca_pkg::OFF_MONTH_DAY,
                           rtca_pkg::OFF_WDAY_HOUR, rtca_pkg::OFF_MIN_SEC};
  // month byte of the time month/day register is read-only, so it stays zero
  logic [15:0] msk[4] = '{rtca_pkg::YEAR_MASK, rtca_pkg::MONTH_DAY_MASK & 16'h00FF,
                          rtca_pkg::WDAY_HOUR_MASK, rtca_pkg::MIN_SEC_MASK};
  logic [15:0] wmsk[3] = '{rtca_pkg::MIN_SEC_MASK, rtca_pkg::WDAY_HOUR_MASK,
                           rtca_pkg::MONTH_DAY_MASK};

  // 250 MHz clock
  always #2 aclk = ~aclk;

  rtca_alarm_regs uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .half_sec_tick(half_sec_tick), .second_half(second_half),
    .alarm_event(alarm_event), .alarm_pulse(alarm_pulse)
  );

  // count alarm pulses seen on the interrupt output
  always @(posedge aclk) begin
    if (!aresetn) ev_cnt <= 0;
    else if (alarm_event === 1'b1) ev_cnt <= ev_cnt + 1;
  end

  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // readiness is sampled 1 ns after an edge: outputs hold until the next edge
  task automatic wr(input logic [7:0] a, input logic [15:0] dv, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, dv};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      #1;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (tb !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] r);
    logic ta, tb;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      #1;
      ta = arvalid && arready;
      tb = rvalid;
      dv = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (tb !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  // one half-second tick; the model covers the every-tick, every-second and minute codes
  task automatic tick(input logic sh);
    @(posedge aclk);
    half_sec_tick <= 1'b1;
    second_half <= sh;
    @(posedge aclk);
    half_sec_tick <= 1'b0;
    if (m_cfg[15] && (m_cfg[13:10] == 4'h0 || (m_cfg[13:10] == 4'h1 && !sh)
        || (m_cfg[13:10] == 4'h3 && !sh && m_hit))) begin
      m_ev++;
      if (m_cfg[7:0] != 8'h00) m_cfg[7:0] = m_cfg[7:0] - 8'h01;
      else if (m_cfg[14]) m_cfg[7:0] = 8'hFF;
      else m_cfg[15] = 1'b0;
    end
    rd(rtca_pkg::OFF_ALARM_CFG, d, rsp);
    #1;
    chk(d, {16'h0000, m_cfg}, "alarm cfg");
    chk(32'(ev_cnt), 32'(m_ev), "alarm events");
    chk({31'h0, alarm_pulse}, {31'h0, m_ev[0]}, "alarm pulse");
  endtask : tick

  task automatic end_sim();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // ------------------------------------------------
  // tests
  // ------------------------------------------------
  initial begin
    void'($urandom(42494));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(rtca_pkg::OFF_ALARM_CFG, d, rsp);
    chk(d, {16'h0000, rtca_pkg::ALARM_CFG_RESET}, "cfg reset");
    $display("test reset done");
    // digits kept within every field's bcd range by the 5555 mask
    for (int i = 0; i < 4; i++) begin
      nv = 16'($urandom()) & 16'h5555;
      wr(offs[i], nv, rsp);
      rd(offs[i], d, rsp);
      chk(d, 32'h0, "locked write");
      wr(rtca_pkg::OFF_TIME_CTRL, 16'h0001, rsp);
      wr(offs[i], nv, rsp);
      rd(offs[i], d, rsp);
      chk(d, {16'h0000, nv & msk[i]}, "time value");
      wr(rtca_pkg::OFF_TIME_CTRL, 16'h0000, rsp);
    end
    $display("test time values done");
    wr(8'h1C, 16'hFFFF, rsp);
    chk({30'h0, rsp}, {30'h0, rtca_pkg::RESP_SLVERR}, "unmapped write");
    rd(8'h1C, d, rsp);
    chk({d[29:0], rsp}, {30'h0, rtca_pkg::RESP_SLVERR}, "unmapped read");
    $display("test unmapped done");
    wr(rtca_pkg::OFF_ALARM_CFG, 16'h0200, rsp);
    for (int i = 2; i >= 0; i--) begin
      v[i] = 16'($urandom()) & 16'h5555;
      wr(rtca_pkg::OFF_ALARM_WIN, v[i], rsp);
    end
    rd(rtca_pkg::OFF_ALARM_CFG, d, rsp);
    chk(d, 32'h0, "ptr floor after writes");
    wr(rtca_pkg::OFF_ALARM_CFG, 16'h0200, rsp);
    for (int i = 2; i >= -1; i--) begin
      rd(rtca_pkg::OFF_ALARM_WIN, d, rsp);
      chk(d, {16'h0000, v[i < 0 ? 0 : i] & wmsk[i < 0 ? 0 : i]}, "alarm window");
    end
    wr(rtca_pkg::OFF_ALARM_CFG, 16'h0300, rsp);
    rd(rtca_pkg::OFF_ALARM_WIN, d, rsp);
    chk(d, 32'h0, "unimplemented pair");
    rd(rtca_pkg::OFF_ALARM_CFG, d, rsp);
    chk(d, 32'h0000_0200, "ptr step on read");
    $display("test alarm window done");
    // only the defined interval codes are ever written
    m_cfg = 16'h8002;
    wr(rtca_pkg::OFF_ALARM_CFG, m_cfg, rsp);
    repeat (4) tick(1'b0);
    m_cfg = 16'hC000;
    wr(rtca_pkg::OFF_ALARM_CFG, m_cfg, rsp);
    repeat (2) tick(1'b0);
    m_cfg = 16'h8403;
    wr(rtca_pkg::OFF_ALARM_CFG, m_cfg, rsp);
    repeat (6) tick(1'($urandom_range(1)));
    $display("test alarm repeat done");
    // every-minute alarm: seconds digits must agree, second pass differs in tens
    wr(rtca_pkg::OFF_TIME_CTRL, 16'h0001, rsp);
    for (int i = 0; i < 2; i++) begin
      nv = 16'($urandom()) & 16'h5555;
      v[0] = nv ^ {11'h000, 1'(i), 4'h0};
      m_hit = (nv[6:0] == v[0][6:0]);
      wr(rtca_pkg::OFF_MIN_SEC, nv, rsp);
      wr(rtca_pkg::OFF_ALARM_WIN, v[0], rsp);
      m_cfg = 16'h8C00;
      wr(rtca_pkg::OFF_ALARM_CFG, m_cfg, rsp); // interval 0011 is not reserved
      tick(1'b1);
      tick(1'b0);
    end
    wr(rtca_pkg::OFF_TIME_CTRL, 16'h0000, rsp);
    $display("test minute match done");
    end_sim();
  end

  // hang guard: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end
endmodule : tb_top
